// *** design/sps_pkg.sv ***
// Contract
// RQ1 - Status variant drives half pin low for lower half, high for upper half.
// RQ2 - Status variant changes halves in split mode only at counts 255 and 511.
// RQ3 - At a boundary the other half's tap loads; next clock accesses that half.
// RQ4 - Switch variant honours the half-switch input only in split mode.
// RQ5 - Half-switch sampled high on a serial clock rise switches to other half.
// RQ6 - The clock that samples the switch high still completes its own access.
// RQ7 - After a forced switch the next clock uses the other half's stored tap.
// RQ8 - Forced switch acts as stop address, any block size from either half.
// RQ9 - No latency cycles between stop point and loading the next half's tap.
// RQ10 - Both variants behave identically apart from the half pin's direction; the code also differs in forced switching and pointer register bit 10.
// RQ11 - Two equal halves, 0 to 255 and 256 to 511, each with its own tap.
package sps_pkg;

  // Buffer pointer geometry
  localparam int PTR_W = 9;
  localparam int TAP_W = 8;
  localparam logic [TAP_W-1:0] HALF_LAST = 8'hFF;

  // Register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TAP_LO = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TAP_HI = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_POINTER = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

  // Control field positions
  localparam int CTRL_SPLIT_BIT = 0;
  localparam int CTRL_INPUT_BIT = 1;
  localparam int CTRL_START_BIT = 2;

  // Pointer register field positions
  localparam int PTRREG_HALF_BIT = 9;
  localparam int PTRREG_VARIANT_BIT = 10;

  // Status field positions
  localparam int STAT_OVERRUN_BIT = 0;
  localparam int STAT_PEND_BIT = 1;

  // Values after reset
  localparam logic [TAP_W-1:0] TAP_LO_RST = 8'h00;
  localparam logic [TAP_W-1:0] TAP_HI_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 9'h000;

  // Access record leaving through the buffer: forced, write, pointer
  localparam int REC_W = PTR_W + 2;
  localparam int FIFO_DEPTH = 4;

endpackage

// *** design/sps_fifo.sv ***
`timescale 1ns/1ns
module sps_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // Storage needs no reset; only the bookkeeping does
  always_ff @(posedge clock_i) begin
    mem_q <= mem_d;
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule

// *** design/sps_split_half_ctrl.sv ***
`timescale 1ns/1ns
module sps_split_half_ctrl #(
  parameter bit SWITCH_VARIANT = 1'b0,
  parameter int FIFO_DEPTH = sps_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [sps_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [sps_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [sps_pkg::DATA_W-1:0] reg_rdata_o,
  // Serial clock pin from the controller
  input wire logic serial_shift_clock_i,
  // Shared half pin
  input wire logic split_half_i,
  output logic split_half_o,
  output logic split_half_oe_o,
  // Access stream toward the buffer array
  output logic access_valid_o,
  input wire logic access_ready_i,
  output logic [sps_pkg::PTR_W-1:0] access_addr_o,
  output logic access_write_o,
  output logic access_forced_o
);

  // Pin synchronisers
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic sw_s1_q, sw_s2_q;

  // Register state
  logic split_q, split_d;
  logic input_mode_q, input_mode_d;
  logic [sps_pkg::TAP_W-1:0] tap_lo_q, tap_lo_d;
  logic [sps_pkg::TAP_W-1:0] tap_hi_q, tap_hi_d;
  logic overrun_q, overrun_d;
  logic [sps_pkg::DATA_W-1:0] rdata_q, rdata_d;

  // Serial stepping state
  logic [sps_pkg::PTR_W-1:0] ptr_q, ptr_d;
  logic pend_q, pend_d;
  logic pend_sw_q, pend_sw_d;
  logic half_pin_q, half_pin_d;

  // Decoded events
  logic sclk_rise;
  logic step_go;
  logic forced;
  logic boundary;
  logic start_wr;
  logic fifo_in_ready;
  logic [sps_pkg::REC_W-1:0] rec_in;
  logic [sps_pkg::REC_W-1:0] rec_out;

  // Two flops on each pin before anything looks at it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= serial_shift_clock_i;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sw_s1_q <= split_half_i;
      sw_s2_q <= sw_s1_q;
    end
  end

  // Both pins pass the same depth, so the switch level lines up with the edge
  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;

  // Software start of a transfer
  assign start_wr = reg_write_i && (reg_addr_i == sps_pkg::OFS_CTRL)
                    && reg_wdata_i[sps_pkg::CTRL_START_BIT];

  // An access is retired only when the buffer can take its record
  assign step_go = pend_q & fifo_in_ready;

  // Forced switch honoured only in split mode on the switch variant
  assign forced = SWITCH_VARIANT && split_q && pend_sw_q; // RQ4 RQ5 RQ8

  // Natural boundary at the last count of either half
  assign boundary = split_q && (ptr_q[sps_pkg::TAP_W-1:0] == sps_pkg::HALF_LAST); // RQ2 RQ11

  // The record carries the current pointer, so the switching clock still accesses
  assign rec_in = {forced, input_mode_q, ptr_q}; // RQ6

  // Pending edge bookkeeping
  always_comb begin
    pend_d = pend_q;
    pend_sw_d = pend_sw_q;
    overrun_d = overrun_q;
    if (step_go) begin
      pend_d = 1'b0;
      pend_sw_d = 1'b0;
    end
    if (sclk_rise) begin
      pend_d = 1'b1;
      pend_sw_d = sw_s2_q; // RQ5
      if (pend_q && !step_go) begin
        overrun_d = 1'b1;
      end
    end
    if (start_wr) begin
      pend_d = 1'b0;
      pend_sw_d = 1'b0;
    end
    // Clear by writing one; a fresh overrun in that cycle wins
    if (reg_write_i && (reg_addr_i == sps_pkg::OFS_STATUS)
        && reg_wdata_i[sps_pkg::STAT_OVERRUN_BIT]
        && !(sclk_rise && pend_q && !step_go)) begin
      overrun_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      pend_sw_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      pend_sw_q <= pend_sw_d;
      overrun_q <= overrun_d;
    end
  end

  // Pointer advance; the tap load happens in the same step, no idle cycle
  always_comb begin
    ptr_d = ptr_q;
    if (start_wr) begin
      ptr_d = {1'b0, tap_lo_q};
    end else if (step_go) begin
      if (forced || boundary) begin
        if (ptr_q[sps_pkg::PTR_W-1]) begin
          ptr_d = {1'b0, tap_lo_q}; // RQ3 RQ7 RQ9
        end else begin
          ptr_d = {1'b1, tap_hi_q}; // RQ3 RQ7 RQ9
        end
      end else begin
        // Plain mode simply wraps through all 512 places
        ptr_d = ptr_q + 9'h001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ptr_q <= sps_pkg::PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Half pin: status flag follows the pointer's upper bit
  always_comb begin
    half_pin_d = ptr_q[sps_pkg::PTR_W-1]; // RQ1
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      half_pin_q <= 1'b0;
    end else begin
      half_pin_q <= half_pin_d;
    end
  end

  // Pin direction, forced switching and the pointer register's variant bit differ between variants
  assign split_half_o = SWITCH_VARIANT ? 1'b0 : half_pin_q; // RQ1 RQ10
  assign split_half_oe_o = ~SWITCH_VARIANT; // RQ10

  // Register writes
  always_comb begin
    split_d = split_q;
    input_mode_d = input_mode_q;
    tap_lo_d = tap_lo_q;
    tap_hi_d = tap_hi_q;
    if (reg_write_i) begin
      unique case (reg_addr_i)
        sps_pkg::OFS_CTRL: begin
          split_d = reg_wdata_i[sps_pkg::CTRL_SPLIT_BIT];
          input_mode_d = reg_wdata_i[sps_pkg::CTRL_INPUT_BIT];
        end
        sps_pkg::OFS_TAP_LO: begin
          tap_lo_d = reg_wdata_i[sps_pkg::TAP_W-1:0];
        end
        sps_pkg::OFS_TAP_HI: begin
          tap_hi_d = reg_wdata_i[sps_pkg::TAP_W-1:0];
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      split_q <= 1'b0;
      input_mode_q <= 1'b0;
      tap_lo_q <= sps_pkg::TAP_LO_RST;
      tap_hi_q <= sps_pkg::TAP_HI_RST;
    end else begin
      split_q <= split_d;
      input_mode_q <= input_mode_d;
      tap_lo_q <= tap_lo_d;
      tap_hi_q <= tap_hi_d;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        sps_pkg::OFS_CTRL: begin
          rdata_d[sps_pkg::CTRL_SPLIT_BIT] = split_q;
          rdata_d[sps_pkg::CTRL_INPUT_BIT] = input_mode_q;
        end
        sps_pkg::OFS_TAP_LO: begin
          rdata_d[sps_pkg::TAP_W-1:0] = tap_lo_q;
        end
        sps_pkg::OFS_TAP_HI: begin
          rdata_d[sps_pkg::TAP_W-1:0] = tap_hi_q;
        end
        sps_pkg::OFS_POINTER: begin
          rdata_d[sps_pkg::PTR_W-1:0] = ptr_q;
          rdata_d[sps_pkg::PTRREG_HALF_BIT] = ptr_q[sps_pkg::PTR_W-1];
          rdata_d[sps_pkg::PTRREG_VARIANT_BIT] = SWITCH_VARIANT;
        end
        sps_pkg::OFS_STATUS: begin
          rdata_d[sps_pkg::STAT_OVERRUN_BIT] = overrun_q;
          rdata_d[sps_pkg::STAT_PEND_BIT] = pend_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Access records queue here; a stalled sink holds off further steps
  sps_fifo #(
    .WIDTH(sps_pkg::REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(step_go),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rec_in),
    .out_valid_o(access_valid_o),
    .out_ready_i(access_ready_i),
    .out_data_o(rec_out)
  );

  // Unpack the head record
  assign access_addr_o = rec_out[sps_pkg::PTR_W-1:0];
  assign access_write_o = rec_out[sps_pkg::PTR_W];
  assign access_forced_o = rec_out[sps_pkg::PTR_W+1];

endmodule

// *** bench/sps_ctrl_model.sv ***
`timescale 1ns/1ns
module sps_ctrl_model (
  // Clock
  input wire logic clock_i,
  // Stall request from the bench
  input wire logic stall_i,
  // Serial pins toward the device
  output logic sclk_o,
  output logic sw_o,
  // Access sink
  output logic ready_o
);
  // Clock rests low between frames, switch idles low
  initial begin
    sclk_o = 1'b0;
    sw_o = 1'b0;
  end
  // Sink may stall to back the buffer up
  assign ready_o = !stall_i;
  // One serial clock; switch held over the whole pulse since it is synchronised alike
  task automatic pulse(input logic sw);
    @(posedge clock_i);
    sw_o <= sw;
    sclk_o <= 1'b1;
    repeat (3) @(posedge clock_i);
    sclk_o <= 1'b0;
    repeat (3) @(posedge clock_i);
    sw_o <= 1'b0;
  endtask
endmodule

// *** bench/sps_asserts.sv ***
`timescale 1ns/1ns
module sps_asserts #(
  parameter bit SWITCH_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [sps_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [sps_pkg::DATA_W-1:0] reg_rdata_o,
  // Serial and half pins
  input wire logic serial_shift_clock_i,
  input wire logic split_half_o,
  input wire logic split_half_oe_o,
  // Access stream
  input wire logic access_valid_o,
  input wire logic access_ready_i,
  input wire logic [sps_pkg::PTR_W-1:0] access_addr_o,
  input wire logic access_write_o,
  input wire logic access_forced_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic pop;
  logic lv_q;
  logic lf_q;
  logic sc_q;
  logic [8:0] la_q;
  logic [3:0] since_q;
  assign pop = access_valid_o && access_ready_i;
  // Last popped access; a restart breaks the sequence, so forget it
  always_ff @(posedge clock_i) begin
    if (rst_i || (reg_write_i && reg_addr_i == sps_pkg::OFS_CTRL)) lv_q <= 1'b0;
    else if (pop) lv_q <= 1'b1;
    if (pop) la_q <= access_addr_o;
    if (pop) lf_q <= access_forced_o;
    sc_q <= serial_shift_clock_i;
    if (rst_i) since_q <= 4'hF;
    else if (serial_shift_clock_i && !sc_q) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  a_oe_variant: assert property (split_half_oe_o == !SWITCH_VARIANT)
    else $error("half pin enable wrong for variant");
  a_half_quiet: assert property (SWITCH_VARIANT |-> !split_half_o)
    else $error("half pin driven in switch variant");
  a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  a_valid_hold: assert property (access_valid_o && !access_ready_i |=> access_valid_o
    && $stable(access_addr_o) && $stable(access_write_o) && $stable(access_forced_o))
    else $error("access changed while stalled");
  a_seq_step: assert property (pop && lv_q && !lf_q && la_q[7:0] != 8'hFF
    |-> access_addr_o == la_q + 9'h001) else $error("pointer step wrong");
  a_bound_flip: assert property (pop && lv_q && la_q[7:0] == 8'hFF
    |-> access_addr_o[8] != la_q[8]) else $error("no half change at boundary");
  a_rise_push: assert property ($rose(serial_shift_clock_i) && !access_valid_o
    |-> ##[1:8] access_valid_o) else $error("serial clock gave no access");
  a_no_spont: assert property ($rose(access_valid_o) |-> since_q <= 4'h8)
    else $error("access without serial clock");
  a_reset_vals: assert property ($fell(rst_i) |-> !access_valid_o && reg_rdata_o == '0)
    else $error("outputs not at reset values");
  c_forced: cover property (pop && access_forced_o);
  c_stall: cover property ((access_valid_o && !access_ready_i) [*4]);
  c_wrap: cover property (pop && lv_q && la_q[7:0] == 8'hFF);
endmodule
bind sps_split_half_ctrl sps_asserts #(.SWITCH_VARIANT(SWITCH_VARIANT)) i_sps_asserts (
  .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .serial_shift_clock_i(serial_shift_clock_i), .split_half_o(split_half_o),
  .split_half_oe_o(split_half_oe_o), .access_valid_o(access_valid_o),
  .access_ready_i(access_ready_i), .access_addr_o(access_addr_o),
  .access_write_o(access_write_o), .access_forced_o(access_forced_o));

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] a = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic stall = 1'b0;
  logic sclk, sw, ready, half, oe, pin, valid, wmode, forced;
  logic half_s, oe_s;
  logic [8:0] addr;
  logic [10:0] got[$];
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clock_i = ~clock_i;
  // Shared half wire: device level when enabled, else the controller's
  assign pin = oe ? half : sw;
  sps_split_half_ctrl #(.SWITCH_VARIANT(1'b1)) i_sps_split_half_ctrl (.clock_i(clock_i),
    .rst_i(rst_i), .reg_addr_i(a), .reg_wdata_i(wd), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .serial_shift_clock_i(sclk), .split_half_i(pin),
    .split_half_o(half), .split_half_oe_o(oe), .access_valid_o(valid),
    .access_ready_i(ready), .access_addr_o(addr), .access_write_o(wmode),
    .access_forced_o(forced));
  // Status variant on the same stimulus; it drives the half pin and ignores the switch
  sps_split_half_ctrl #(.SWITCH_VARIANT(1'b0))
    i_sps_split_half_ctrl_status (.clock_i(clock_i),
    .rst_i(rst_i), .reg_addr_i(a), .reg_wdata_i(wd), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(), .serial_shift_clock_i(sclk), .split_half_i(sw),
    .split_half_o(half_s), .split_half_oe_o(oe_s), .access_valid_o(),
    .access_ready_i(ready), .access_addr_o(), .access_write_o(),
    .access_forced_o());
  sps_ctrl_model i_sps_ctrl_model (.clock_i(clock_i), .stall_i(stall), .sclk_o(sclk),
    .sw_o(sw), .ready_o(ready));
  // Collect accepted records; cut a hang short
  always @(posedge clock_i) begin
    if (valid && ready) got.push_back({forced, wmode, addr});
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    a <= ad;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] ad, output logic [31:0] d);
    @(posedge clock_i);
    a <= ad;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // Oldest record against expectation, masked bits only
  task automatic rec(input logic [10:0] e, input logic [10:0] m);
    logic [10:0] r;
    repeat (40) if (got.size() == 0) @(posedge clock_i);
    r = (got.size() != 0) ? got.pop_front() : ~e;
    chk("record", 32'(e & m), 32'(r & m));
  endtask
  task automatic t_reset;
    logic [31:0] d;
    rd(sps_pkg::OFS_POINTER, d);
    chk("pointer", 32'h400, d);
    rd(sps_pkg::OFS_TAP_HI, d);
    chk("tap_hi", 32'h0, d);
    rd(5'h14, d);
    chk("unmapped", 32'h0, d);
    chk("half_oe", 32'h0, 32'(oe));
    chk("half_oe_status", 32'h1, 32'(oe_s));
    chk("half_status", 32'h0, 32'(half_s));
  endtask
  // Switch input high outside split mode must not move the pointer
  task automatic t_nonsplit;
    wr(sps_pkg::OFS_TAP_HI, 32'h80);
    wr(sps_pkg::OFS_CTRL, 32'h4);
    i_sps_ctrl_model.pulse(1'b1);
    i_sps_ctrl_model.pulse(1'b0);
    rec(11'h000, 11'h7FF);
    rec(11'h001, 11'h7FF);
  endtask
  // Natural boundaries at 255 and 511 load the other tap
  task automatic t_bound;
    logic [31:0] d;
    logic [8:0] e[8] = '{9'h0FC, 9'h0FD, 9'h0FE, 9'h0FF, 9'h1FD, 9'h1FE, 9'h1FF, 9'h0FC};
    wr(sps_pkg::OFS_TAP_LO, 32'hFC);
    wr(sps_pkg::OFS_TAP_HI, 32'hFD);
    wr(sps_pkg::OFS_CTRL, 32'h5);
    for (int i = 0; i < 8; i++) begin
      i_sps_ctrl_model.pulse(1'b0);
      if (i == 3) begin
        rd(sps_pkg::OFS_POINTER, d);
        chk("half_status", 32'h1, 32'(half_s));
      end
    end
    chk("half_status", 32'h0, 32'(half_s));
    chk("pointer", 32'h7FD, d);
    for (int i = 0; i < 8; i++) rec({2'b00, e[i]}, 11'h7FF);
  endtask
  // Forced stops in both halves, serial input mode
  task automatic t_forced;
    logic [31:0] d;
    logic [5:0] s = 6'b010100;
    logic [10:0] e[6] = '{11'h220, 11'h221, 11'h622, 11'h340, 11'h741, 11'h220};
    wr(sps_pkg::OFS_TAP_LO, 32'h20);
    wr(sps_pkg::OFS_TAP_HI, 32'h40);
    wr(sps_pkg::OFS_CTRL, 32'h7);
    rd(sps_pkg::OFS_CTRL, d);
    chk("ctrl", 32'h3, d);
    for (int i = 0; i < 6; i++) i_sps_ctrl_model.pulse(s[i]);
    for (int i = 0; i < 6; i++) rec(e[i], 11'h7FF);
  endtask
  // Fill the buffer until it refuses, then drain to empty
  task automatic t_overrun;
    logic [31:0] d;
    wr(sps_pkg::OFS_CTRL, 32'h5);
    @(posedge clock_i);
    stall <= 1'b1;
    repeat (6) i_sps_ctrl_model.pulse(1'b0);
    chk("valid", 32'h1, 32'(valid));
    rd(sps_pkg::OFS_STATUS, d);
    chk("overrun", 32'h1, d & 32'h1);
    chk("pending", 32'h2, d & 32'h2);
    got.delete();
    wr(sps_pkg::OFS_CTRL, 32'h5);
    @(posedge clock_i);
    stall <= 1'b0;
    repeat (20) @(posedge clock_i);
    chk("valid", 32'h0, 32'(valid));
    chk("drained", 32'(sps_pkg::FIFO_DEPTH), 32'(got.size()));
    wr(sps_pkg::OFS_STATUS, 32'h1);
    rd(sps_pkg::OFS_STATUS, d);
    chk("overrun", 32'h0, d & 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_nonsplit();
    t_bound();
    t_forced();
    t_overrun();
    close_out();
  end
endmodule
